//--- include/swsl_pkg.sv
// Shared constants, types and helpers of the single-wire sensor read link
package swsl_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 28;
  localparam int FRAME_BITS = 40;
  localparam logic [5:0] LAST_BIT = 6'h27;
  localparam int NEG_BIT = 7;

  // Interval figures in ns
  localparam int T_PWRUP_NS = 1_000_000_000;
  localparam int T_GAP_NS = 2_000_000_000;
  localparam int T_START_NS = 20_000_000;
  localparam int T_START_MIN_NS = 10_000_000;
  localparam int T_START_MAX_NS = 50_000_000;
  localparam int T_GO_NS = 13_000;
  localparam int T_RLOW_NS = 83_000;
  localparam int T_RHIGH_NS = 87_000;
  localparam int T_BLOW_NS = 54_000;
  localparam int T_ZERO_NS = 24_000;
  localparam int T_ONE_NS = 71_000;
  localparam int T_END_NS = 54_000;
  localparam int T_TMO_NS = 300_000;
  localparam int T_THR_NS = 50_000;

  // Cycle counts: least times round up, longest times round down
  localparam int C_PWRUP = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_GAP = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_START = T_START_NS / CLK_PERIOD_NS;
  localparam int C_START_MIN = (T_START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_START_MAX = T_START_MAX_NS / CLK_PERIOD_NS;
  localparam int C_GO = T_GO_NS / CLK_PERIOD_NS;
  localparam int C_RLOW = T_RLOW_NS / CLK_PERIOD_NS;
  localparam int C_RHIGH = T_RHIGH_NS / CLK_PERIOD_NS;
  localparam int C_BLOW = T_BLOW_NS / CLK_PERIOD_NS;
  localparam int C_ZERO = T_ZERO_NS / CLK_PERIOD_NS;
  localparam int C_ONE = T_ONE_NS / CLK_PERIOD_NS;
  localparam int C_END = T_END_NS / CLK_PERIOD_NS;
  localparam int C_TMO = T_TMO_NS / CLK_PERIOD_NS;
  localparam int C_THR = T_THR_NS / CLK_PERIOD_NS;

  typedef logic [CNT_W-1:0] swsl_cnt_t;

  typedef enum logic [3:0] {
    SNS_IDLE = 4'h0,
    SNS_START = 4'h1,
    SNS_GO = 4'h3,
    SNS_RLOW = 4'h2,
    SNS_RHIGH = 4'h6,
    SNS_BLOW = 4'h7,
    SNS_BHIGH = 4'h5,
    SNS_ELOW = 4'h4,
    SNS_MEAS = 4'hC
  } swsl_sns_st_t;

  typedef enum logic [3:0] {
    HST_PWR = 4'h0,
    HST_IDLE = 4'h1,
    HST_START = 4'h3,
    HST_WRESP = 4'h2,
    HST_RLOW = 4'h6,
    HST_RHIGH = 4'h7,
    HST_BLOW = 4'h5,
    HST_BHIGH = 4'h4,
    HST_ELOW = 4'hC,
    HST_GAP = 4'hD
  } swsl_hst_st_t;

  // Check byte: 8-bit sum of the four data bytes
  function automatic logic [7:0] swsl_sum(input logic [31:0] d);
    return d[31:24] + d[23:16] + d[15:8] + d[7:0];
  endfunction

endpackage

//--- include/swsl_link_if.sv
// Open-drain single data wire shared by host and sensor
`timescale 1ns/100ps
interface swsl_link_if;
  logic host_oe;
  logic host_dout;
  logic sensor_oe;
  logic sensor_dout;
  logic line;

  // Pull-up: high unless an enabled driver pulls low
  assign line = ~((host_oe & ~host_dout) | (sensor_oe & ~sensor_dout));

  modport host (output host_oe, output host_dout, input line);
  modport sensor (output sensor_oe, output sensor_dout, input line);
endinterface

//--- hw/swsl_sensor.sv
// Sensor end of the single-wire read link
// What the host and sensor ends do
// - Host waits one second after power-up
// - Idle sensor releases line and watches it
// - Host start low lasts at least 18 ms
// - Sensor answers with low then high response
// - Host skips response high before data bits
// - Zero bit: 54 us low, short high
// - One bit: 54 us low, long high
// - Closing low after bit forty, then release
// - New measurement stored after each frame
// - Host start low between 10 and 50 ms
// - Response low starts 10 to 35 us after release
// - Response low lasts 78 to 88 us
// - Response high lasts 80 to 92 us
// - Closing low lasts 52 to 56 us
// - Host keeps all intervals within limits
// - Forty bits, MSB first, four bytes plus check
// - Host drops frame on bad check, rereads
// - Temperature fraction MSB marks negative temperature
// - Reads two seconds apart return previous measurement
`timescale 1ns/100ps
module swsl_sensor #(
  parameter int START_MIN_CYC = swsl_pkg::C_START_MIN,
  parameter int START_MAX_CYC = swsl_pkg::C_START_MAX,
  parameter int RLOW_CYC = swsl_pkg::C_RLOW,
  parameter int RHIGH_CYC = swsl_pkg::C_RHIGH,
  parameter int BLOW_CYC = swsl_pkg::C_BLOW,
  parameter int ZERO_CYC = swsl_pkg::C_ZERO,
  parameter int ONE_CYC = swsl_pkg::C_ONE,
  parameter int END_CYC = swsl_pkg::C_END
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Asynchronous reset
  swsl_link_if.sensor link, // Shared data wire
  input wire logic meas_valid, // Measurement ready
  input wire logic [7:0] meas_hum_int, // Humidity integer
  input wire logic [7:0] meas_hum_frac, // Humidity fraction
  input wire logic [7:0] meas_temp_int, // Temperature integer
  input wire logic [6:0] meas_temp_frac, // Temperature fraction
  input wire logic meas_temp_neg, // Temperature below zero
  output logic meas_req, // Asks for a measurement
  output logic busy, // Frame in progress
  output logic frame_sent // Frame finished pulse
);

  typedef struct packed {
    swsl_pkg::swsl_sns_st_t state;
    swsl_pkg::swsl_cnt_t cnt;
    logic [5:0] bit_idx;
    logic [39:0] shift;
    logic [31:0] meas;
    logic [2:0] sync;
    logic line_f;
    logic drive;
    logic meas_req;
    logic busy;
    logic sent;
  } swsl_sns_reg_t;

  localparam swsl_sns_reg_t SNS_RST = '{
    state: swsl_pkg::SNS_MEAS,
    cnt: '0,
    bit_idx: '0,
    shift: '0,
    meas: '0,
    sync: 3'h7,
    line_f: 1'b1,
    drive: 1'b0,
    meas_req: 1'b1,
    busy: 1'b0,
    sent: 1'b0
  };

  swsl_sns_reg_t st_q;
  swsl_sns_reg_t st_d;

  // True on the last cycle of an interval of n cycles
  function automatic logic hit(input swsl_pkg::swsl_cnt_t c, input int n);
    return c == swsl_pkg::swsl_cnt_t'(n - 1);
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], link.line};
    if (st_q.sync[2] == st_q.sync[1]) begin
      st_d.line_f = st_q.sync[2];
    end
    st_d.cnt = st_q.cnt + 1'b1;
    st_d.sent = 1'b0;
    case (st_q.state)
      swsl_pkg::SNS_IDLE: begin
        st_d.drive = 1'b0;
        st_d.busy = 1'b0;
        if (!st_q.line_f) begin
          st_d.state = swsl_pkg::SNS_START;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::SNS_START: begin
        if (st_q.line_f) begin
          st_d.cnt = '0;
          // Start low must fit its window, else ignored
          if (st_q.cnt >= swsl_pkg::swsl_cnt_t'(START_MIN_CYC) &&
              st_q.cnt <= swsl_pkg::swsl_cnt_t'(START_MAX_CYC)) begin
            st_d.state = swsl_pkg::SNS_GO;
            st_d.busy = 1'b1;
          end else begin
            st_d.state = swsl_pkg::SNS_IDLE;
          end
        end else if (&st_q.cnt) begin
          st_d.cnt = st_q.cnt;
        end
      end
      swsl_pkg::SNS_GO: begin
        if (hit(st_q.cnt, swsl_pkg::C_GO)) begin
          st_d.drive = 1'b1;
          st_d.state = swsl_pkg::SNS_RLOW;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::SNS_RLOW: begin
        if (hit(st_q.cnt, RLOW_CYC)) begin
          st_d.drive = 1'b0;
          st_d.state = swsl_pkg::SNS_RHIGH;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::SNS_RHIGH: begin
        if (hit(st_q.cnt, RHIGH_CYC)) begin
          st_d.drive = 1'b1;
          st_d.state = swsl_pkg::SNS_BLOW;
          st_d.cnt = '0;
          st_d.bit_idx = '0;
          st_d.shift = {st_q.meas, swsl_pkg::swsl_sum(st_q.meas)};
        end
      end
      swsl_pkg::SNS_BLOW: begin
        if (hit(st_q.cnt, BLOW_CYC)) begin
          st_d.drive = 1'b0;
          st_d.state = swsl_pkg::SNS_BHIGH;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::SNS_BHIGH: begin
        // High length carries the bit value
        if ((!st_q.shift[39] && hit(st_q.cnt, ZERO_CYC)) ||
            (st_q.shift[39] && hit(st_q.cnt, ONE_CYC))) begin
          st_d.drive = 1'b1;
          st_d.cnt = '0;
          st_d.shift = {st_q.shift[38:0], 1'b0};
          st_d.bit_idx = st_q.bit_idx + 1'b1;
          if (st_q.bit_idx == swsl_pkg::LAST_BIT) begin
            st_d.state = swsl_pkg::SNS_ELOW;
          end else begin
            st_d.state = swsl_pkg::SNS_BLOW;
          end
        end
      end
      swsl_pkg::SNS_ELOW: begin
        if (hit(st_q.cnt, END_CYC)) begin
          st_d.drive = 1'b0;
          st_d.state = swsl_pkg::SNS_MEAS;
          st_d.busy = 1'b0;
          st_d.sent = 1'b1;
          st_d.meas_req = 1'b1;
        end
      end
      swsl_pkg::SNS_MEAS: begin
        st_d.drive = 1'b0;
        if (meas_valid) begin
          st_d.meas = {meas_hum_int, meas_hum_frac, meas_temp_int, meas_temp_neg, meas_temp_frac};
          st_d.meas_req = 1'b0;
          st_d.state = swsl_pkg::SNS_IDLE;
        end
      end
      default: begin
        st_d.drive = 1'b0;
        st_d.state = swsl_pkg::SNS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= SNS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.sensor_oe = st_q.drive;
  assign link.sensor_dout = 1'b0;
  assign meas_req = st_q.meas_req;
  assign busy = st_q.busy;
  assign frame_sent = st_q.sent;

endmodule

//--- hw/swsl_host.sv
// Host end of the single-wire read link
`timescale 1ns/100ps
module swsl_host #(
  parameter int PWRUP_CYC = swsl_pkg::C_PWRUP,
  parameter int GAP_CYC = swsl_pkg::C_GAP,
  parameter int START_CYC = swsl_pkg::C_START,
  parameter int TMO_CYC = swsl_pkg::C_TMO,
  parameter int THR_CYC = swsl_pkg::C_THR
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Asynchronous reset
  swsl_link_if.host link, // Shared data wire
  input wire logic req, // Read request
  output logic ready, // Accepts a request
  output logic done, // Good frame pulse
  output logic err_timeout, // Missing edge pulse
  output logic err_check, // Check byte mismatch pulse
  output logic [7:0] hum_int, // Humidity integer
  output logic [7:0] hum_frac, // Humidity fraction
  output logic [7:0] temp_int, // Temperature integer
  output logic [6:0] temp_frac, // Temperature fraction
  output logic temp_neg // Temperature below zero
);

  typedef struct packed {
    swsl_pkg::swsl_hst_st_t state;
    swsl_pkg::swsl_cnt_t cnt;
    logic [5:0] bit_idx;
    logic [39:0] shift;
    logic [31:0] data;
    logic [2:0] sync;
    logic line_f;
    logic drive;
    logic ready;
    logic retry;
    logic done;
    logic err_timeout;
    logic err_check;
  } swsl_hst_reg_t;

  localparam swsl_hst_reg_t HST_RST = '{
    state: swsl_pkg::HST_PWR,
    cnt: '0,
    bit_idx: '0,
    shift: '0,
    data: '0,
    sync: 3'h7,
    line_f: 1'b1,
    drive: 1'b0,
    ready: 1'b0,
    retry: 1'b0,
    done: 1'b0,
    err_timeout: 1'b0,
    err_check: 1'b0
  };

  swsl_hst_reg_t st_q;
  swsl_hst_reg_t st_d;

  function automatic logic hit(input swsl_pkg::swsl_cnt_t c, input int n);
    return c == swsl_pkg::swsl_cnt_t'(n - 1);
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], link.line};
    if (st_q.sync[2] == st_q.sync[1]) begin
      st_d.line_f = st_q.sync[2];
    end
    st_d.cnt = st_q.cnt + 1'b1;
    st_d.done = 1'b0;
    st_d.err_timeout = 1'b0;
    st_d.err_check = 1'b0;
    case (st_q.state)
      swsl_pkg::HST_PWR: begin
        if (hit(st_q.cnt, PWRUP_CYC)) begin
          st_d.state = swsl_pkg::HST_IDLE;
          st_d.ready = 1'b1;
        end
      end
      swsl_pkg::HST_IDLE: begin
        if (req || st_q.retry) begin
          st_d.drive = 1'b1;
          st_d.ready = 1'b0;
          st_d.retry = 1'b0;
          st_d.state = swsl_pkg::HST_START;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::HST_START: begin
        if (hit(st_q.cnt, START_CYC)) begin
          st_d.drive = 1'b0;
          st_d.state = swsl_pkg::HST_WRESP;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::HST_WRESP: begin
        // Own start low still in the filter: act only on a fresh fall
        if (st_q.line_f && !st_q.sync[2] && !st_q.sync[1]) begin
          st_d.state = swsl_pkg::HST_RLOW;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::HST_RLOW: begin
        if (st_q.line_f) begin
          st_d.state = swsl_pkg::HST_RHIGH;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::HST_RHIGH: begin
        if (!st_q.line_f) begin
          st_d.state = swsl_pkg::HST_BLOW;
          st_d.bit_idx = '0;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::HST_BLOW: begin
        if (st_q.line_f) begin
          st_d.state = swsl_pkg::HST_BHIGH;
          st_d.cnt = '0;
        end
      end
      swsl_pkg::HST_BHIGH: begin
        if (!st_q.line_f) begin
          st_d.shift = {st_q.shift[38:0], st_q.cnt >= swsl_pkg::swsl_cnt_t'(THR_CYC)};
          st_d.bit_idx = st_q.bit_idx + 1'b1;
          st_d.cnt = '0;
          if (st_q.bit_idx == swsl_pkg::LAST_BIT) begin
            st_d.state = swsl_pkg::HST_ELOW;
          end else begin
            st_d.state = swsl_pkg::HST_BLOW;
          end
        end
      end
      swsl_pkg::HST_ELOW: begin
        if (st_q.line_f) begin
          st_d.state = swsl_pkg::HST_GAP;
          st_d.cnt = '0;
          if (swsl_pkg::swsl_sum(st_q.shift[39:8]) == st_q.shift[7:0]) begin
            st_d.data = st_q.shift[39:8];
            st_d.done = 1'b1;
          end else begin
            st_d.err_check = 1'b1;
            st_d.retry = 1'b1;
          end
        end
      end
      swsl_pkg::HST_GAP: begin
        if (hit(st_q.cnt, GAP_CYC)) begin
          st_d.state = swsl_pkg::HST_IDLE;
          st_d.ready = ~st_q.retry;
        end
      end
      default: begin
        st_d.state = swsl_pkg::HST_IDLE;
      end
    endcase
    // Abort when an expected edge does not come
    if (st_q.state inside {swsl_pkg::HST_WRESP, swsl_pkg::HST_RLOW, swsl_pkg::HST_RHIGH,
        swsl_pkg::HST_BLOW, swsl_pkg::HST_BHIGH, swsl_pkg::HST_ELOW} &&
        st_d.state == st_q.state && hit(st_q.cnt, TMO_CYC)) begin
      st_d.err_timeout = 1'b1;
      st_d.state = swsl_pkg::HST_GAP;
      st_d.cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= HST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.host_oe = st_q.drive;
  assign link.host_dout = 1'b0;
  assign ready = st_q.ready;
  assign done = st_q.done;
  assign err_timeout = st_q.err_timeout;
  assign err_check = st_q.err_check;
  assign hum_int = st_q.data[31:24];
  assign hum_frac = st_q.data[23:16];
  assign temp_int = st_q.data[15:8];
  assign temp_neg = st_q.data[swsl_pkg::NEG_BIT];
  assign temp_frac = st_q.data[6:0];

endmodule

//--- dv/swsl_assertions.sv
// Timing checks on the wire between host and sensor
`timescale 1ns/100ps
module swsl_assertions #(
  parameter int START_CYC = 200,
  parameter int RLOW_CYC = 830,
  parameter int RHIGH_CYC = 870,
  parameter int BLOW_CYC = 540,
  parameter int ZERO_CYC = 2400,
  parameter int ONE_CYC = 2900,
  parameter int END_CYC = 540
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Asynchronous reset
  input wire logic host_oe, // Host pulls wire
  input wire logic host_dout, // Host data
  input wire logic sensor_oe, // Sensor pulls wire
  input wire logic sensor_dout, // Sensor data
  input wire logic line // Resolved wire
);
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic [15:0] st_q;
  logic [5:0] idx_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // Run lengths of each wire phase and count of sensor pulls
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lo_q <= 16'h0;
      hi_q <= 16'h0;
      st_q <= 16'h0;
      idx_q <= 6'h0;
    end else begin
      lo_q <= sensor_oe ? lo_q + 16'h1 : 16'h0;
      hi_q <= (sensor_oe | host_oe) ? 16'h0 : hi_q + 16'h1;
      st_q <= host_oe ? st_q + 16'h1 : 16'h0;
      if (host_oe)
        idx_q <= 6'h0;
      else if ($rose(sensor_oe))
        idx_q <= idx_q + 6'h1;
    end
  end

  sequence s_resp_rise;
    $rose(sensor_oe) && idx_q == 6'h0;
  endsequence
  sequence s_sns_hold;
    (sensor_oe && !line) [*8];
  endsequence

  a_start_len: assert property ($fell(host_oe) |-> st_q == START_CYC)
    else $error("host start low length wrong");
  a_go_delay: assert property (s_resp_rise |-> hi_q >= 16'h03E8 && hi_q <= 16'h0DAC)
    else $error("response start delay out of range");
  a_host_quiet: assert property (s_resp_rise |-> !host_oe throughout s_sns_hold)
    else $error("host drives during sensor response");
  a_drive_low: assert property ((host_oe || sensor_oe) |-> !line && !host_dout && !sensor_dout)
    else $error("driven wire not low");
  a_resp_low: assert property ($fell(sensor_oe) && idx_q == 6'h01 |-> lo_q == RLOW_CYC)
    else $error("response low length wrong");
  a_resp_high: assert property ($rose(sensor_oe) && idx_q == 6'h01 |-> hi_q == RHIGH_CYC)
    else $error("response high length wrong");
  a_bit_low: assert property ($fell(sensor_oe) && idx_q inside {[2:41]} |-> lo_q == BLOW_CYC)
    else $error("bit low length wrong");
  a_bit_high: assert property ($rose(sensor_oe) && idx_q inside {[2:41]} |->
    hi_q == ZERO_CYC || hi_q == ONE_CYC)
    else $error("bit high length wrong");
  a_close_low: assert property ($fell(sensor_oe) && idx_q == 6'h2A |-> lo_q == END_CYC)
    else $error("closing low length wrong");
  a_frame_end: assert property ($rose(sensor_oe) |-> idx_q < 6'h2A)
    else $error("sensor drives after closing low");
endmodule

//--- dv/swsl_tb.sv
// Bench for both link ends plus a scripted sensor facing a second host
`timescale 1ns/100ps
module swsl_tb;
  localparam int THR = 50;
  localparam int T_SMIN = 100;
  localparam int T_SMAX = 5000;
  localparam int T_RLOW = 83;
  localparam int T_RHIGH = 87;
  localparam int T_BLOW = 54;
  localparam int T_ZERO = 24;
  localparam int T_ONE = 71;
  localparam int T_END = 54;
  localparam int T_PWR = 50;
  localparam int T_GAP = 50;
  localparam int T_START = 200;
  localparam int T_TMO = 4000;
  localparam int T_TMO2 = 400;
  localparam int T_THR2 = 60;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic req2 = 1'b0;
  logic meas_valid = 1'b0;
  logic [31:0] md = 32'h0;
  logic [31:0] d;
  logic [31:0] mq[$];
  logic [39:0] wire_bits = 40'h0;
  logic prev_line = 1'b1;
  logic ok;
  logic ok2;
  int nfall = 0;
  int hcnt = 0;
  int miscompares = 0;
  int cmp_count = 0;
  wire meas_req;
  wire [9:0] fl;
  wire [31:0] hd;
  wire [31:0] hd2;

  swsl_link_if link();
  swsl_link_if link2();

  swsl_sensor #(.START_MIN_CYC(T_SMIN), .START_MAX_CYC(T_SMAX), .RLOW_CYC(T_RLOW), .RHIGH_CYC(T_RHIGH),
    .BLOW_CYC(T_BLOW), .ZERO_CYC(T_ZERO), .ONE_CYC(T_ONE), .END_CYC(T_END)) swsl_sensor_inst (.clock(clock),
    .resetn(resetn), .link(link.sensor),
    .meas_valid(meas_valid), .meas_hum_int(md[31:24]), .meas_hum_frac(md[23:16]), .meas_temp_int(md[15:8]),
    .meas_temp_frac(md[6:0]), .meas_temp_neg(md[7]), .meas_req(meas_req), .busy(fl[9]), .frame_sent(fl[8]));
  swsl_host #(.PWRUP_CYC(T_PWR), .GAP_CYC(T_GAP), .START_CYC(T_START), .TMO_CYC(T_TMO), .THR_CYC(THR))
    swsl_host_inst (
    .clock(clock), .resetn(resetn), .link(link.host), .req(req), .ready(fl[0]), .done(fl[1]),
    .err_timeout(fl[2]), .err_check(fl[3]), .hum_int(hd[31:24]), .hum_frac(hd[23:16]), .temp_int(hd[15:8]),
    .temp_frac(hd[6:0]), .temp_neg(hd[7]));
  swsl_host #(.PWRUP_CYC(T_PWR), .GAP_CYC(T_GAP), .START_CYC(T_START), .TMO_CYC(T_TMO2), .THR_CYC(T_THR2))
    fault_swsl_host_inst (
    .clock(clock), .resetn(resetn), .link(link2.host), .req(req2), .ready(fl[4]), .done(fl[5]),
    .err_timeout(fl[6]), .err_check(fl[7]), .hum_int(hd2[31:24]), .hum_frac(hd2[23:16]), .temp_int(hd2[15:8]),
    .temp_frac(hd2[6:0]), .temp_neg(hd2[7]));
  swsl_assertions #(.START_CYC(T_START), .RLOW_CYC(T_RLOW), .RHIGH_CYC(T_RHIGH), .BLOW_CYC(T_BLOW),
    .ZERO_CYC(T_ZERO), .ONE_CYC(T_ONE), .END_CYC(T_END)) swsl_assertions_inst (.clock(clock), .resetn(resetn),
    .host_oe(link.host_oe),
    .host_dout(link.host_dout), .sensor_oe(link.sensor_oe), .sensor_dout(link.sensor_dout), .line(link.line));

  initial begin
    forever #5 clock = ~clock;
  end

  // Measurement source: first value wraps the check sum and is negative
  always @(negedge clock) begin
    if (meas_req === 1'b1 && !meas_valid) begin
      md = (mq.size() == 0) ? 32'hFFFF_FFFF : $urandom;
      mq.push_back(md);
      meas_valid = 1'b1;
    end else if (meas_req === 1'b0) begin
      meas_valid = 1'b0;
    end
  end

  // Decodes the main wire from high lengths before each fall
  always @(posedge clock) begin
    if (link.host_oe === 1'b1) begin
      nfall = 0;
    end else if (prev_line && !link.line) begin
      if (nfall >= 2 && nfall <= 41)
        wire_bits = {wire_bits[38:0], hcnt > THR};
      nfall++;
    end
    hcnt = link.line ? hcnt + 1 : 0;
    prev_line = link.line;
  end

  function automatic logic [39:0] exp_frame(input logic [31:0] v);
    logic [7:0] s;
    s = v[31:24] + v[23:16] + v[15:8] + v[7:0];
    return {v, s};
  endfunction

  task automatic cmp_vec(input string nm, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_ev(input string nm, input logic g);
    cmp_vec(nm, 40'h1, {39'h0, g});
  endtask

  task automatic wait_ev(input int i, input int lim, output logic got);
    got = 1'b0;
    repeat (lim) begin
      @(negedge clock);
      if (fl[i] === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  task automatic drive2(input logic oe, input int n);
    link2.sensor_oe = oe;
    repeat (n) @(negedge clock);
  endtask

  task automatic send2(input logic [39:0] f);
    drive2(1'b1, 100);
    drive2(1'b0, 100);
    for (int k = 39; k >= 0; k--) begin
      drive2(1'b1, 30);
      drive2(1'b0, f[k] ? 100 : 20);
    end
    drive2(1'b1, 30);
    drive2(1'b0, 1);
  endtask

  // Waits out a start low of the second host, then the go delay
  task automatic start2(output logic got);
    int n;
    n = 0;
    while (link2.host_oe !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    while (link2.host_oe === 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    repeat (20) @(negedge clock);
    got = n < 2000;
  endtask

  task automatic pulse_req(input int i);
    logic got;
    wait_ev(i, 100, got);
    if (i == 0)
      req = 1'b1;
    else
      req2 = 1'b1;
    @(negedge clock);
    if (i == 0)
      req = 1'b0;
    else
      req2 = 1'b0;
  endtask

  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    finish_test();
  end

  initial begin
    d = $urandom(32'hE32D);
    link2.sensor_oe = 1'b0;
    link2.sensor_dout = 1'b0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    repeat (10) @(negedge clock);
    cmp_ev("ready_early", fl[0] === 1'b0);
    fork
      for (int f = 0; f < 2; f++) begin
        pulse_req(0);
        wait_ev(9, 2000, ok);
        cmp_ev("busy", ok);
        wait_ev(8, 15000, ok);
        cmp_ev("frame_sent", ok);
        cmp_ev("busy_end", fl[9] === 1'b0);
        wait_ev(1, 10, ok);
        cmp_ev("done", ok);
        cmp_vec("host_data", {8'h0, mq[f]}, {8'h0, hd});
        cmp_vec("wire_bits", exp_frame(mq[f]), wire_bits);
        cmp_ev("line_idle", link.line === 1'b1);
      end
      begin
        pulse_req(4);
        start2(ok2);
        cmp_ev("start2", ok2);
        d = $urandom;
        send2(exp_frame(d) ^ 40'h1);
        wait_ev(7, 10, ok2);
        cmp_ev("err_check", ok2);
        start2(ok2);
        cmp_ev("retry_start", ok2);
        send2(exp_frame(d));
        wait_ev(5, 10, ok2);
        cmp_ev("done2", ok2);
        cmp_vec("host2_data", {8'h0, d}, {8'h0, hd2});
        pulse_req(4);
        wait_ev(6, 1000, ok2);
        cmp_ev("err_timeout", ok2);
      end
    join
    finish_test();
  end
endmodule
